/* inc/led_defines.svh */
// constants for the node status indicator encoder: offsets, fields, resets, timing
`ifndef LED_DEFINES_SVH
`define LED_DEFINES_SVH

// ==================================================================
// register byte offsets on the apb bus
`define LED_CTRL_ADDR     12'h000
`define LED_ERR_ADDR      12'h004
`define LED_STAT_ADDR     12'h008

// ==================================================================
// control register field positions
`define LED_CTRL_STAGE_LSB 0
`define LED_CTRL_POWERED   2
`define LED_CTRL_MF_HALT   3
`define LED_CTRL_MF_ACT    4
`define LED_CTRL_RX_ERR    5
`define LED_CTRL_TX_ERR    6
`define LED_CTRL_EXCESS    7
`define LED_CTRL_XMIT      8
`define LED_CTRL_HW_ERR    9
`define LED_CTRL_BUS_ERR   10
`define LED_CTRL_CFG_MODE  11
`define LED_CTRL_SPEED_LSB 12
`define LED_CTRL_WIDTH     16

// ==================================================================
// error flag register: one bit per fault, bit n reports type n+1
`define LED_ERR_WIDTH      5

// ==================================================================
// reset values
`define LED_CTRL_RST       16'h0000
`define LED_ERR_RST        5'h00

// ==================================================================
// timing: one base tick is 50 ms, everything else counts ticks
`define LED_CLK_KHZ        125000
`define LED_TICK_MS        50
`define LED_TICK_CYCLES    (`LED_TICK_MS * `LED_CLK_KHZ)
`define LED_SLOW_HALF      3'h5
`define LED_BURST_HALF     6'h01
`define LED_DIGIT_HALF     6'h0A
`define LED_PAUSE_SHORT    6'h14
`define LED_PAUSE_LONG     6'h28
`define LED_BURST_BLINKS   4'h5
`define LED_ERR_CODE_HW    4'h1

`endif

/* inc/led_pkg.sv */
// types shared by the node status indicator encoder
package led_pkg;

  // node stage as written by software
  typedef enum logic [1:0] {
    STG_INIT  = 2'h0,
    STG_PREOP = 2'h1,
    STG_OPER  = 2'h2,
    STG_STOP  = 2'h3
  } stage_t;

  // error report sequencer, one-hot
  typedef enum logic [6:0] {
    RPT_IDLE   = 7'h01,
    RPT_BURST  = 7'h02,
    RPT_PAUSE1 = 7'h04,
    RPT_CODE   = 7'h08,
    RPT_PAUSE2 = 7'h10,
    RPT_TYPE   = 7'h20,
    RPT_PAUSE3 = 7'h40
  } rpt_state_t;

endpackage

/* logic/blink_timebase.sv */
// base tick and the two square blink rates for the indicators
`timescale 1ns/100ps
`include "led_defines.svh"

module blink_timebase #(
  parameter int TICK_CYCLES = `LED_TICK_CYCLES
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  output logic      tick_o,   // one-cycle pulse every base tick
  output logic      fast_o,   // square wave, toggles every tick
  output logic      slow_o    // square wave, toggles every few ticks
);

  logic [22:0] div_reg;       // cycle divider
  logic [2:0]  slow_reg;      // tick count for the slow wave

  // ==================================================================
  // cycle divider: the 50 ms tick
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      div_reg <= 23'h000000;
      tick_o  <= 1'b0;
    end else if (div_reg == 23'(TICK_CYCLES - 1)) begin
      div_reg <= 23'h000000;
      tick_o  <= 1'b1;
    end else begin
      div_reg <= div_reg + 23'h000001;
      tick_o  <= 1'b0;
    end
  end

  // ==================================================================
  // fast wave: on one tick, off one tick, i.e. 10 Hz
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      fast_o <= 1'b0;
    end else if (tick_o) begin
      fast_o <= ~fast_o;
    end
  end

  // ==================================================================
  // slow wave: half period of several ticks
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      slow_reg <= 3'h0;
      slow_o   <= 1'b0;
    end else if (tick_o) begin
      if (slow_reg == `LED_SLOW_HALF - 3'h1) begin
        slow_reg <= 3'h0;
        slow_o   <= ~slow_o;
      end else begin
        slow_reg <= slow_reg + 3'h1;
      end
    end
  end

endmodule

/* logic/node_led_encoder.sv */
// node status indicator encoder with apb control and cyclic error report
//
// What this block does
// (R1) unpowered or initializing: halt, active dark
// (R2) pre-operative, no fault: active blinks slow
// (R3) operative: halt dark, active steadily lit
// (R4) stop stage: halt lit, active dark
// (R5) pre-operative module fault: fast blink instead
// (R6) fault leds follow rx/tx errors, dark initializing
// (R7) excessive errors: both fault leds blink fast
// (R8) bus led: dark, green transmitting, red hardware
// (R9) initializing: bus led blinks orange
// (R10) init ok gives green, problem keeps red blinking
// (R11) error report repeats: three sequences with pauses
// (R12) first sequence is a 10 Hz burst
// (R13) pause, then error code blinks at 1 Hz
// (R14) longer pause, type blinks at 1 Hz, restart
// (R15) code 1 means hardware or configuration fault
// (R16) type 1: internal data memory overflow
// (R17) type 2: wrong i/o module in node
// (R18) types 3,4,5: nonvolatile checksum, write, read
// (R19) configuration mode shows selected speed instead
// (R20) all rates come from parameterised dividers
// (R21) reset darkens all, restarts the report
`timescale 1ns/100ps
`include "led_defines.svh"

module node_led_encoder #(
  parameter int TICK_CYCLES = `LED_TICK_CYCLES
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             halt_led_o,
  output logic             active_led_o,
  output logic             tx_fault_led_o,
  output logic             rx_fault_led_o,
  output logic             io_red_o,
  output logic             io_green_o,
  output led_pkg::stage_t  stage_o
);
  import led_pkg::*;

  // ==================================================================
  // declarations
  logic [`LED_CTRL_WIDTH-1:0] ctrl_reg;     // node state written by software
  logic [`LED_ERR_WIDTH-1:0]  err_reg;      // fault flags, code 1 family
  rpt_state_t                 rpt_reg;      // report sequencer state
  rpt_state_t                 rpt_next;     // its next value
  logic [5:0]                 seg_reg;      // ticks spent in segment
  logic [3:0]                 blinks_reg;   // blinks done in sequence
  logic                       on_reg;       // report lamp phase
  logic                       tick;         // base tick pulse
  logic                       fast;         // 10 Hz square
  logic                       slow;         // slow square
  logic                       access;       // apb access phase edge
  logic                       mapped;       // address decodes
  logic                       seg_end;      // segment finishes this tick
  logic                       rpt_run;      // report may run
  logic [3:0]                 err_type;     // type shown third
  stage_t                     stage;        // decoded stage
  logic                       powered, cfg_mode;              // decoded control bits
  logic                       halt_next, act_next, tx_next;   // top lamp next values
  logic                       rx_next, red_next, green_next;  // remaining next values

  // ==================================================================
  // functions
  // lowest set fault wins, bit n is type n+1
  function automatic logic [3:0] fault_type(input logic [`LED_ERR_WIDTH-1:0] f);
    fault_type = 4'h0;
    for (int i = `LED_ERR_WIDTH - 1; i >= 0; i--) begin
      if (f[i]) begin
        fault_type = 4'(i + 1);
      end
    end
  endfunction
  // length in ticks of a half blink or a pause
  function automatic logic [5:0] seg_len(input rpt_state_t s);
    case (s)
      RPT_BURST:  seg_len = `LED_BURST_HALF;
      RPT_CODE:   seg_len = `LED_DIGIT_HALF;
      RPT_TYPE:   seg_len = `LED_DIGIT_HALF;
      RPT_PAUSE1: seg_len = `LED_PAUSE_SHORT;
      default:    seg_len = `LED_PAUSE_LONG;
    endcase
  endfunction

  // ==================================================================
  // rate generation
  blink_timebase #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timebase (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .tick_o  (tick),
    .fast_o  (fast),
    .slow_o  (slow)
  ); // R20

  // ==================================================================
  // apb decode
  assign access   = psel_i & penable_i & pready_o;
  assign mapped   = (paddr_i == `LED_CTRL_ADDR) | (paddr_i == `LED_ERR_ADDR) |
                    (paddr_i == `LED_STAT_ADDR);
  assign stage    = stage_t'(ctrl_reg[`LED_CTRL_STAGE_LSB +: 2]);
  assign powered  = ctrl_reg[`LED_CTRL_POWERED];
  assign cfg_mode = ctrl_reg[`LED_CTRL_CFG_MODE];
  assign err_type = fault_type(err_reg); // R16 R17 R18
  // register writes land only on the completing edge
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctrl_reg <= `LED_CTRL_RST;
      err_reg  <= `LED_ERR_RST;
    end else if (access && pwrite_i) begin
      if (paddr_i == `LED_CTRL_ADDR) begin
        ctrl_reg <= pwdata_i[`LED_CTRL_WIDTH-1:0];
      end
      if (paddr_i == `LED_ERR_ADDR) begin
        err_reg <= pwdata_i[`LED_ERR_WIDTH-1:0];
      end
    end
  end
  // one wait state: pready rises in the first access cycle's edge
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else if (psel_i && penable_i && !pready_o) begin
      pready_o  <= 1'b1;
      pslverr_o <= ~mapped;
      // unmapped reads return zero with an error
      case (paddr_i)
        `LED_CTRL_ADDR: prdata_o <= {16'h0000, ctrl_reg};
        `LED_ERR_ADDR:  prdata_o <= {27'h0000000, err_reg};
        `LED_STAT_ADDR: prdata_o <= {10'h000, err_type, blinks_reg, rpt_reg, on_reg,
                                     halt_led_o, active_led_o, tx_fault_led_o,
                                     rx_fault_led_o, io_red_o, io_green_o};
        default:        prdata_o <= 32'h00000000;
      endcase
    end else begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // ==================================================================
  // error report sequencer
  // runs only once the node has left initializing and has a fault
  assign rpt_run = powered & ~cfg_mode & (stage != STG_INIT) & (err_type != 4'h0); // R11
  assign seg_end = tick & (seg_reg == seg_len(rpt_reg) - 6'h01);
  // next state of the sequencer
  always_comb begin
    rpt_next = rpt_reg;
    case (rpt_reg)
      RPT_IDLE: begin
        rpt_next = RPT_BURST; // R12
      end
      RPT_BURST: begin
        if (seg_end && !on_reg && blinks_reg == `LED_BURST_BLINKS - 4'h1) begin
          rpt_next = RPT_PAUSE1;
        end
      end
      RPT_PAUSE1: begin
        if (seg_end) begin
          rpt_next = RPT_CODE; // R13
        end
      end
      RPT_CODE: begin
        // code 1 is the only family handled here
        if (seg_end && !on_reg && blinks_reg == `LED_ERR_CODE_HW - 4'h1) begin
          rpt_next = RPT_PAUSE2; // R15
        end
      end
      RPT_PAUSE2: begin
        if (seg_end) begin
          rpt_next = RPT_TYPE; // R14
        end
      end
      RPT_TYPE: begin
        if (seg_end && !on_reg && blinks_reg == err_type - 4'h1) begin
          rpt_next = RPT_PAUSE3;
        end
      end
      RPT_PAUSE3: begin
        if (seg_end) begin
          rpt_next = RPT_BURST; // R14
        end
      end
      default: begin
        rpt_next = RPT_IDLE;
      end
    endcase
    if (!rpt_run) begin
      rpt_next = RPT_IDLE;
    end
  end
  // state, segment timer, blink count and lamp phase
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rpt_reg    <= RPT_IDLE; // R21
      seg_reg    <= 6'h00;
      blinks_reg <= 4'h0;
      on_reg     <= 1'b0;
    end else if (rpt_next != rpt_reg) begin
      // every new segment starts fresh, blinks begin lit
      rpt_reg    <= rpt_next;
      seg_reg    <= 6'h00;
      blinks_reg <= 4'h0;
      on_reg     <= (rpt_next == RPT_BURST) | (rpt_next == RPT_CODE) |
                    (rpt_next == RPT_TYPE);
    end else if (seg_end) begin
      seg_reg <= 6'h00;
      if (on_reg) begin
        on_reg <= 1'b0;
      end else if (rpt_reg != RPT_IDLE) begin
        blinks_reg <= blinks_reg + 4'h1;
        on_reg     <= 1'b1;
      end
    end else if (tick) begin
      seg_reg <= seg_reg + 6'h01;
    end
  end

  // ==================================================================
  // indicator selection
  always_comb begin
    halt_next  = 1'b0;
    act_next   = 1'b0;
    tx_next    = 1'b0;
    rx_next    = 1'b0;
    red_next   = 1'b0;
    green_next = 1'b0;
    if (cfg_mode) begin
      // speed switches shown blinking on the top four lamps
      halt_next = ctrl_reg[`LED_CTRL_SPEED_LSB]     & slow; // R19
      act_next  = ctrl_reg[`LED_CTRL_SPEED_LSB + 1] & slow;
      tx_next   = ctrl_reg[`LED_CTRL_SPEED_LSB + 2] & slow;
      rx_next   = ctrl_reg[`LED_CTRL_SPEED_LSB + 3] & slow;
    end else if (powered) begin
      case (stage)
        STG_PREOP: begin
          if (ctrl_reg[`LED_CTRL_MF_HALT] || ctrl_reg[`LED_CTRL_MF_ACT]) begin
            halt_next = ctrl_reg[`LED_CTRL_MF_HALT] & fast; // R5
            act_next  = ctrl_reg[`LED_CTRL_MF_ACT] & fast;
          end else begin
            act_next = slow; // R2
          end
        end
        STG_OPER: begin
          act_next = 1'b1; // R3
        end
        STG_STOP: begin
          halt_next = 1'b1; // R4
        end
        default: begin
          halt_next = 1'b0; // R1
        end
      endcase
      if (stage != STG_INIT) begin
        if (ctrl_reg[`LED_CTRL_EXCESS]) begin
          tx_next = fast; // R7
          rx_next = fast;
        end else begin
          tx_next = ctrl_reg[`LED_CTRL_TX_ERR]; // R6
          rx_next = ctrl_reg[`LED_CTRL_RX_ERR];
        end
      end
      // bus lamp: report beats all, then stage, then bus state
      if (rpt_reg != RPT_IDLE) begin
        red_next = on_reg; // R10
      end else if (stage == STG_INIT) begin
        red_next   = slow; // R9
        green_next = slow;
      end else if (ctrl_reg[`LED_CTRL_HW_ERR]) begin
        red_next = 1'b1; // R8
      end else if (ctrl_reg[`LED_CTRL_BUS_ERR]) begin
        red_next = slow;
      end else begin
        green_next = ctrl_reg[`LED_CTRL_XMIT]; // R8
      end
    end
  end

  // every lamp leaves a flop
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      halt_led_o     <= 1'b0; // R21
      active_led_o   <= 1'b0;
      tx_fault_led_o <= 1'b0;
      rx_fault_led_o <= 1'b0;
      io_red_o       <= 1'b0;
      io_green_o     <= 1'b0;
      stage_o        <= STG_INIT;
    end else begin
      halt_led_o     <= halt_next;
      active_led_o   <= act_next;
      tx_fault_led_o <= tx_next;
      rx_fault_led_o <= rx_next;
      io_red_o       <= red_next;
      io_green_o     <= green_next;
      stage_o        <= stage;
    end
  end

  // ==================================================================
  // assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  property p_dark_init;
    (!cfg_mode && (!powered || stage == STG_INIT)) |=>
      !halt_led_o && !active_led_o && !tx_fault_led_o && !rx_fault_led_o;
  endproperty
  a_dark_init: assert property (p_dark_init) else $error("lamps lit while init"); // R1
  property p_oper;
    (!cfg_mode && powered && stage == STG_OPER) |=> active_led_o && !halt_led_o;
  endproperty
  a_oper: assert property (p_oper) else $error("operative lamps wrong"); // R3
  property p_stop;
    (!cfg_mode && powered && stage == STG_STOP) |=> halt_led_o && !active_led_o;
  endproperty
  a_stop: assert property (p_stop) else $error("stop lamps wrong"); // R4
  property p_fault_follow;
    (!cfg_mode && powered && stage != STG_INIT && !ctrl_reg[`LED_CTRL_EXCESS]) |=>
      tx_fault_led_o == $past(ctrl_reg[`LED_CTRL_TX_ERR]) &&
      rx_fault_led_o == $past(ctrl_reg[`LED_CTRL_RX_ERR]);
  endproperty
  a_fault_follow: assert property (p_fault_follow) else $error("fault lamp mismatch"); // R6
  property p_orange;
    (!cfg_mode && powered && stage == STG_INIT) |=> io_red_o == io_green_o;
  endproperty
  a_orange: assert property (p_orange) else $error("init bus lamp not orange"); // R9
  property p_hw_red;
    (!cfg_mode && powered && stage != STG_INIT && ctrl_reg[`LED_CTRL_HW_ERR] &&
     rpt_reg == RPT_IDLE) |=> io_red_o && !io_green_o;
  endproperty
  a_hw_red: assert property (p_hw_red) else $error("hardware error not red"); // R8
  property p_report_start;
    (rpt_reg == RPT_IDLE && rpt_run) |=> rpt_reg == RPT_BURST && on_reg;
  endproperty
  a_report_start: assert property (p_report_start) else $error("report did not start"); // R12
  property p_code_count;
    (rpt_reg == RPT_CODE) |-> blinks_reg < `LED_ERR_CODE_HW;
  endproperty
  a_code_count: assert property (p_code_count) else $error("code blink overrun"); // R13
  property p_report_red;
    (rpt_reg != RPT_IDLE && !cfg_mode) |=> !io_green_o && io_red_o == $past(on_reg);
  endproperty
  a_report_red: assert property (p_report_red) else $error("report lamp wrong"); // R11
  property p_reset_dark;
    $fell(rst_i) |-> !io_red_o && !io_green_o && !halt_led_o && rpt_reg == RPT_IDLE;
  endproperty
  a_reset_dark: assert property (p_reset_dark) else $error("not dark after reset"); // R21

  c_report_type:  cover property (rpt_reg == RPT_TYPE && err_type == 4'h3);
  c_cfg_speed:    cover property (cfg_mode && halt_led_o);
  c_preop_fault:  cover property (stage == STG_PREOP && halt_led_o && active_led_o);
  c_report_wrap:  cover property (rpt_reg == RPT_PAUSE3 ##1 rpt_reg == RPT_BURST);

endmodule

/* testbench/lamp_observer.sv */
// behavioural observer that times the pulses seen on one indicator lamp
`timescale 1ns/100ps

module lamp_observer (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic lamp_i
);
  // ==================================================================
  // pulse log
  int   lens[$];  // lit length of every finished pulse, in clocks
  int   gaps[$];  // dark length that came before each pulse
  int   on_cnt;   // clocks lit so far
  int   off_cnt;  // clocks dark so far
  int   gap_hold; // dark run that preceded the current pulse
  logic prev;     // lamp level one clock ago

  // an eye sees whole pulses only, so a pulse is logged when it ends
  always @(posedge clock_i) begin
    if (rst_i) begin
      prev = 1'b0;
      on_cnt = 0;
      off_cnt = 0;
    end else begin
      if (lamp_i === 1'b1 && prev !== 1'b1) begin
        gap_hold = off_cnt;
        on_cnt = 1;
      end else if (lamp_i === 1'b1) begin
        on_cnt++;
      end
      if (lamp_i !== 1'b1 && prev === 1'b1) begin
        lens.push_back(on_cnt);
        gaps.push_back(gap_hold);
        off_cnt = 1;
      end else if (lamp_i !== 1'b1) begin
        off_cnt++;
      end
      prev = lamp_i;
    end
  end
endmodule

/* testbench/tb_node_led_encoder.sv */
// self-checking bench for the node status indicator encoder
`timescale 1ns/100ps
`include "led_defines.svh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("unexpected %s: expected %0h seen %0h", nm, exp, got); end end

module tb_node_led_encoder;
  import led_pkg::*;
  // ==================================================================
  // stimulus and observation
  localparam int TICK = 4;        // short tick keeps one report near a thousand clocks
  logic          clock_i;
  logic          rst_i;
  logic          psel_i;
  logic          penable_i;
  logic          pwrite_i;
  logic [11:0]   paddr_i;
  logic [31:0]   pwdata_i;
  logic [31:0]   prdata_o;
  logic          pready_o;
  logic          pslverr_o;
  logic          halt_led_o;
  logic          active_led_o;
  logic          tx_fault_led_o;
  logic          rx_fault_led_o;
  logic          io_red_o;
  logic          io_green_o;
  stage_t        stage_o;
  logic [31:0]   rd;              // last read data
  logic          err;             // last error response
  logic [5:0]    lamps;           // halt, active, tx, rx, red, green
  int            ones[6];         // lit clocks per lamp in a watch
  int            flips[6];        // level changes per lamp in a watch
  int            bad_count;
  int            check_count;

  assign lamps = {halt_led_o, active_led_o, tx_fault_led_o, rx_fault_led_o, io_red_o, io_green_o};

  node_led_encoder #(.TICK_CYCLES(TICK)) i_node_led_encoder (
    .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .halt_led_o(halt_led_o),
    .active_led_o(active_led_o), .tx_fault_led_o(tx_fault_led_o),
    .rx_fault_led_o(rx_fault_led_o), .io_red_o(io_red_o), .io_green_o(io_green_o),
    .stage_o(stage_o));

  lamp_observer i_lamp_observer (.clock_i(clock_i), .rst_i(rst_i), .lamp_i(io_red_o));

  // ==================================================================
  // clock and watchdog
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // longest run is five full reports plus short scans, well under this
  initial begin
    repeat (40000) @(posedge clock_i);
    bad_count++;
    wrap_up();
  end

  // ==================================================================
  // shared tasks
  task automatic wrap_up();
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask

  // counts lit clocks and level changes of every lamp
  task automatic watch(input int cyc);
    logic [5:0] last;
    last = lamps;
    for (int i = 0; i < 6; i++) begin
      ones[i] = 0;
      flips[i] = 0;
    end
    repeat (cyc) begin
      @(posedge clock_i);
      for (int i = 0; i < 6; i++) begin
        ones[i] += int'(lamps[i] === 1'b1);
        flips[i] += int'(lamps[i] !== last[i]);
      end
      last = lamps;
    end
  endtask

  // 0 dark, 1 steady, 2 slow blink, 3 fast blink over a 100-clock watch
  function automatic logic [1:0] mode(input int o, input int f);
    if (f == 0) return (o == 0) ? 2'h0 : 2'h1;
    return (f >= 15) ? 2'h3 : 2'h2;
  endfunction

  // ==================================================================
  // scenarios
  task automatic t_reset();
    `CHK("lamps after reset", 6'h00, lamps)
    `CHK("stage after reset", STG_INIT, stage_o)
    apb(1'b1, `LED_ERR_ADDR + 12'h008, 32'hFFFF_FFFF);
    `CHK("unmapped write err", 1'b1, err)
    apb(1'b1, `LED_STAT_ADDR, 32'hFFFF_FFFF);
    apb(1'b0, `LED_STAT_ADDR, 32'h0);
    `CHK("status reset", 32'h0000_0080, rd)
    apb(1'b0, `LED_CTRL_ADDR, 32'h0);
    `CHK("control reset", 32'h0, rd)
  endtask

  // table of control words and the expected look of all six lamps
  task automatic t_table();
    logic [15:0] cv[14];
    logic [11:0] md[14];
    logic [11:0] got;
    cv = '{16'h0062, 16'h0064, 16'h0005, 16'h000D, 16'h0015, 16'h001D, 16'h0026,
           16'h0047, 16'h00A6, 16'h0006, 16'h0106, 16'h0206, 16'h0406, 16'h5804};
    md = '{12'h000, 12'h00A, 12'h200, 12'hC00, 12'h300, 12'hF00, 12'h110,
           12'h440, 12'h1F0, 12'h100, 12'h101, 12'h104, 12'h108, 12'h880};
    for (int r = 0; r < 14; r++) begin
      apb(1'b1, `LED_CTRL_ADDR, {16'h0, cv[r]});
      repeat (2) @(posedge clock_i);
      watch(100);
      for (int i = 0; i < 6; i++) got[2*i +: 2] = mode(ones[i], flips[i]);
      `CHK("lamp modes", md[r], got)
      `CHK("stage copy", stage_t'(cv[r][1:0]), stage_o)
    end
    apb(1'b1, `LED_CTRL_ADDR, 32'h0000_0004);
    repeat (3) @(posedge clock_i);
    `CHK("orange pair", io_red_o, io_green_o)
  endtask

  // one fault flag gives burst, code one, then the type count
  task automatic t_report(input int k);
    int n;
    n = 0;
    apb(1'b1, `LED_CTRL_ADDR, 32'h0000_0006);
    repeat (2) @(posedge clock_i);  // a pulse cut short by the stage change is logged first
    i_lamp_observer.lens.delete();
    i_lamp_observer.gaps.delete();
    apb(1'b1, `LED_ERR_ADDR, 32'h1 << (k - 1));
    while (i_lamp_observer.lens.size() < 7 + k && n < 3000) begin
      @(posedge clock_i);
      n++;
    end
    `CHK("pulse count", 1'b1, i_lamp_observer.lens.size() >= 7 + k)
    for (int i = 1; i < 5; i++) `CHK("burst on", TICK, i_lamp_observer.lens[i])
    `CHK("burst off", TICK, i_lamp_observer.gaps[4])
    `CHK("code on", 10 * TICK, i_lamp_observer.lens[5])
    `CHK("pauses", 1'b1, i_lamp_observer.gaps[6] > i_lamp_observer.gaps[5])
    for (int i = 0; i < k; i++) `CHK("type on", 10 * TICK, i_lamp_observer.lens[6 + i])
    `CHK("report restart", TICK, i_lamp_observer.lens[6 + k])
    apb(1'b1, `LED_ERR_ADDR, 32'h0);
    repeat (3) @(posedge clock_i);
    `CHK("report stopped", 1'b0, io_red_o)
  endtask

  // reset in mid-report darkens everything and clears the flags
  task automatic t_mid_reset();
    apb(1'b1, `LED_ERR_ADDR, 32'h0000_0010);
    repeat (60) @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    `CHK("lamps in reset", 6'h00, lamps)
    rst_i <= 1'b0;
    @(posedge clock_i);
    `CHK("lamps after release", 6'h00, lamps)
    apb(1'b0, `LED_ERR_ADDR, 32'h0);
    `CHK("flags cleared", 32'h0, rd)
  endtask

  // ==================================================================
  // main sequence
  initial begin
    bad_count = 0;
    check_count = 0;
    rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    t_reset();
    t_table();
    for (int k = 1; k <= 5; k++) t_report(k);
    t_mid_reset();
    wrap_up();
  end
endmodule
